// File: common/fcsc_consts.svh
// constants of the flash scan checker: register indexes, fields, resets, timing
// assumes a 32-bit apb slave where byte address = 4 * register index
`ifndef FCSC_CONSTS_SVH
`define FCSC_CONSTS_SVH
`define FCSC_IDX_MAIN        10'h000
`define FCSC_IDX_REGION      10'h001
`define FCSC_IDX_STATE       10'h002
`define FCSC_BIT_ENABLE      0
`define FCSC_BIT_ARM         1
`define FCSC_BIT_SRST        7
`define FCSC_MODE_HI         5
`define FCSC_MODE_LO         4
`define FCSC_SRC_HI          1
`define FCSC_SRC_LO          0
`define FCSC_MAIN_RESET      2'h0
`define FCSC_REGION_RESET    4'h0
`define FCSC_STATE_RESET     2'h2
`define FCSC_MODE_PRIORITY   2'h0
`define FCSC_MODE_INIT       2'h1
`define FCSC_SRC_FLASH       2'h0
`define FCSC_SRC_BOOT_PLUS_APP_REGION     2'h1
`define FCSC_SRC_BOOT        2'h2
`define FCSC_START_CYCLES    2'h3
`define FCSC_FETCH_CYCLES    2'h3
`define FCSC_FLASH_LAST      15'h1fff
`define FCSC_CRC_POLY        16'h1021
`define FCSC_CRC_INIT        16'hffff
`endif

// File: common/fcsc_pkg.sv
// types of the flash scan checker
// assumes fcsc_consts.svh supplies the numbers
package fcsc_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_WAIT  = 4'b0010,
        ST_FETCH = 4'b0100,
        ST_DONE  = 4'b1000
    } fcsc_state_t;
    typedef struct packed {
        logic arm;
        logic enable;
    } fcsc_main_t;
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] src;
    } fcsc_region_t;
    typedef struct packed {
        logic ok;
        logic busy;
    } fcsc_status_t;
    typedef struct packed {
        logic        rd;
        logic [14:0] addr;
    } fcsc_flash_req_t;
endpackage

// File: src/fcsc_top.sv
// flash scan checker: apb registers, scan sequencer, crc and failure interrupt
// assumes flash data returns one cycle after a read strobe, fuses and init pulse on ref_clk
//
// Function
// R1 - armed interrupt fires on checksum mismatch
// R2 - arm bit cleared only by system reset
// R3 - arm set accepted only when not busy
// R4 - enable write one starts fresh check
// R5 - enable zero does not abort check
// R6 - disabled running check still reports failure
// R7 - reset-time scan leaves enable reading one
// R8 - region register locked while busy or failed
// R9 - access setting zero means priority single check
// R10 - software rewrites access setting after init scan
// R11 - region select: flash, boot+app, boot
// R12 - reset-time scan leaves checked region readable
// R13 - status read-only, resets to 0x02
// R14 - pass flag reset set, cleared on enable
// R15 - busy flag reads one during check
// R16 - self-reset strobe clears registers next cycle
// R17 - failure interrupt request held until reset
// R18 - check begins three cycles after enable
// R19 - one flash word every third cycle
// R20 - unimplemented bits read zero
// R21 - main control locked after failure interrupt
`timescale 1ns/1ps
`include "fcsc_consts.svh"

module fcsc_top (
    // clock, reset, enable
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    clk_en,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // flash port
    output fcsc_pkg::fcsc_flash_req_t    flash_req,
    input  wire logic [15:0]             flash_rdata,
    input  wire logic [7:0]              boot_end,
    input  wire logic [7:0]              app_end,
    // reset-time scan launch
    input  wire logic                    init_scan_start,
    input  wire logic [1:0]              init_scan_src,
    // to cpu
    output logic                         cpu_stall,
    output logic                         nmi_req
);

    fcsc_pkg::fcsc_main_t   main_ctl;
    fcsc_pkg::fcsc_region_t region;
    fcsc_pkg::fcsc_status_t status;
    fcsc_pkg::fcsc_state_t  state;
    logic                   srst_pend;
    logic [1:0]             cnt;
    logic [14:0]            last;
    logic [15:0]            crc;
    logic                   apb_wr;
    logic                   apb_rd;
    logic                   wr_main;
    logic                   wr_region;
    logic                   srst_req;
    logic                   start;
    logic                   pass;

    function automatic logic reg_hit(input logic [11:0] a, input logic [9:0] idx);
        reg_hit = (a[11:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
        logic [15:0] r;
        r = c ^ d;
        for (int i = 0; i < 16; i++) begin
            r = r[15] ? ((r << 1) ^ `FCSC_CRC_POLY) : (r << 1);
        end
        crc_step = r;
    endfunction

    // R11 region decode, reserved value scans the whole flash
    function automatic logic [14:0] region_last(input logic [1:0] src);
        case (src)
            `FCSC_SRC_BOOT_PLUS_APP_REGION: region_last = {app_end, 7'h00} - 15'h0001;
            `FCSC_SRC_BOOT:    region_last = {boot_end, 7'h00} - 15'h0001;
            default:           region_last = `FCSC_FLASH_LAST;
        endcase
    endfunction

    assign apb_wr    = psel & penable & pready & pwrite;
    assign apb_rd    = psel & penable & pready & ~pwrite;
    // R21 main control ignores writes after failure
    assign wr_main   = apb_wr & reg_hit(paddr, `FCSC_IDX_MAIN) & ~nmi_req;
    // R8 region writes blocked while busy or failed
    assign wr_region = apb_wr & reg_hit(paddr, `FCSC_IDX_REGION) & ~status.busy & ~nmi_req;
    // R16 strobe honoured when unarmed or idle
    assign srst_req  = wr_main & pwdata[`FCSC_BIT_SRST] & (~main_ctl.arm | ~status.busy);
    // R4 a write of one launches a new check when idle or in the result cycle, not during a running one
    assign start     = ((wr_main & pwdata[`FCSC_BIT_ENABLE]) | init_scan_start) & ~srst_req & ~srst_pend;
    // crc over the region including the stored checksum leaves zero residue
    assign pass      = (crc == 16'h0000);

    // apb handshake: one wait state so every output comes from a flop
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~(reg_hit(paddr, `FCSC_IDX_MAIN) |
                       reg_hit(paddr, `FCSC_IDX_REGION) | reg_hit(paddr, `FCSC_IDX_STATE));
            // R20 unused bits and the strobe read zero
            if (psel & penable & ~pready & ~pwrite) begin
                if (reg_hit(paddr, `FCSC_IDX_MAIN))
                    prdata <= {30'h0000_0000, main_ctl.arm, main_ctl.enable};
                else if (reg_hit(paddr, `FCSC_IDX_REGION))
                    prdata <= {26'h000_0000, region.mode, 2'h0, region.src};
                else if (reg_hit(paddr, `FCSC_IDX_STATE))
                    prdata <= {30'h0000_0000, status.ok, status.busy};
                else
                    prdata <= 32'h0000_0000;
            end else if (apb_rd) begin
                prdata <= prdata;
            end
        end
    end

    // self-reset lands one cycle after the strobe write
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            srst_pend <= 1'b0;
        else if (clk_en)
            srst_pend <= srst_req;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            main_ctl <= `FCSC_MAIN_RESET;
        end else if (clk_en) begin
            // R2 the strobe leaves the arm bit alone
            if (srst_pend)
                main_ctl.enable <= 1'b0;
            // R7 reset-time scan shows as enabled
            else if (init_scan_start)
                main_ctl.enable <= 1'b1;
            // R5 clearing enable only stores the bit
            else if (wr_main)
                main_ctl.enable <= pwdata[`FCSC_BIT_ENABLE];
            // R3 arm accepted only while idle
            if (wr_main & pwdata[`FCSC_BIT_ARM] & ~status.busy)
                main_ctl.arm <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            region <= `FCSC_REGION_RESET;
        end else if (clk_en) begin
            if (srst_pend)
                region <= `FCSC_REGION_RESET;
            // R12 reset-time scan leaves its region and a non-zero mode
            else if (init_scan_start)
                region <= {`FCSC_MODE_INIT, init_scan_src};
            // R9 modes zero and one are defined; other codes stored as written
            else if (wr_region)
                region <= {pwdata[`FCSC_MODE_HI:`FCSC_MODE_LO], pwdata[`FCSC_SRC_HI:`FCSC_SRC_LO]};
        end
    end

    // R13 status has no write path
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status <= `FCSC_STATE_RESET;
        end else if (clk_en) begin
            if (srst_pend) begin
                status <= 2'h0;
            // R14 R15 pass cleared and busy set on launch
            end else if (start) begin
                status.busy <= 1'b1;
                status.ok   <= 1'b0;
            end else if (state == fcsc_pkg::ST_DONE) begin
                status.busy <= 1'b0;
                status.ok   <= pass;
            end
        end
    end

    // R1 R6 R17 armed mismatch raises a request held until reset
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            nmi_req <= 1'b0;
        else if (clk_en && state == fcsc_pkg::ST_DONE && !pass && main_ctl.arm && !srst_pend)
            nmi_req <= 1'b1;
    end

    // scan sequencer; cpu is stalled for the whole fetch phase
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state     <= fcsc_pkg::ST_IDLE;
            cnt       <= 2'h0;
            last      <= 15'h0000;
            crc       <= `FCSC_CRC_INIT;
            flash_req <= '0;
            cpu_stall <= 1'b0;
        end else if (clk_en) begin
            flash_req.rd <= 1'b0;
            if (srst_pend) begin
                state     <= fcsc_pkg::ST_IDLE;
                cpu_stall <= 1'b0;
            end else begin
                case (state)
                    fcsc_pkg::ST_IDLE: begin
                        if (start) begin
                            state <= fcsc_pkg::ST_WAIT;
                            cnt   <= 2'h0;
                        end
                    end
                    // R18 three idle cycles before the first fetch
                    fcsc_pkg::ST_WAIT: begin
                        cnt <= cnt + 2'h1;
                        if (cnt == `FCSC_START_CYCLES - 2'h1) begin
                            state          <= fcsc_pkg::ST_FETCH;
                            cnt            <= 2'h0;
                            crc            <= `FCSC_CRC_INIT;
                            flash_req.addr <= 15'h0000;
                            last           <= region_last(region.src);
                            cpu_stall      <= 1'b1;
                        end
                    end
                    // R19 read, wait, capture: one word per three cycles
                    fcsc_pkg::ST_FETCH: begin
                        cnt <= (cnt == `FCSC_FETCH_CYCLES - 2'h1) ? 2'h0 : cnt + 2'h1;
                        if (cnt == 2'h0)
                            flash_req.rd <= 1'b1;
                        if (cnt == `FCSC_FETCH_CYCLES - 2'h1) begin
                            crc <= crc_step(crc, flash_rdata);
                            if (flash_req.addr == last) begin
                                state     <= fcsc_pkg::ST_DONE;
                                cpu_stall <= 1'b0;
                            end else begin
                                flash_req.addr <= flash_req.addr + 15'h0001;
                            end
                        end
                    end
                    // R4 a relaunch during the result cycle is honoured
                    fcsc_pkg::ST_DONE: begin
                        state <= start ? fcsc_pkg::ST_WAIT : fcsc_pkg::ST_IDLE;
                        cnt   <= 2'h0;
                    end
                    default: state <= fcsc_pkg::ST_IDLE;
                endcase
            end
        end
    end

    chk_nmi_on_fail: assert property (@(posedge ref_clk) disable iff (sys_rst || !clk_en) // R1 R6
        state == fcsc_pkg::ST_DONE && !pass && main_ctl.arm && !srst_pend |=> nmi_req)
        else $error("armed mismatch did not raise interrupt");
    chk_arm_hold: assert property (@(posedge ref_clk) disable iff (sys_rst) // R2
        main_ctl.arm |=> main_ctl.arm)
        else $error("arm bit cleared without system reset");
    chk_arm_busy: assert property (@(posedge ref_clk) disable iff (sys_rst) // R3
        !main_ctl.arm && status.busy |=> !main_ctl.arm)
        else $error("arm bit set while busy");
    chk_start_delay: assert property (@(posedge ref_clk) disable iff (sys_rst || !clk_en || srst_req) // R18
        state == fcsc_pkg::ST_IDLE && start |=> (state == fcsc_pkg::ST_WAIT)[*3] ##1 state == fcsc_pkg::ST_FETCH)
        else $error("check did not begin three cycles after enable");
    chk_fetch_period: assert property (@(posedge ref_clk) disable iff (sys_rst || !clk_en) // R19
        flash_req.rd |=> !flash_req.rd [*2])
        else $error("flash fetched faster than every third cycle");
    chk_region_lock: assert property (@(posedge ref_clk) disable iff (sys_rst) // R8
        (status.busy || nmi_req) && !srst_pend && !init_scan_start |=> region == $past(region))
        else $error("region register changed while locked");
    chk_ok_busy: assert property (@(posedge ref_clk) disable iff (sys_rst) // R14
        status.busy |-> !status.ok)
        else $error("pass flag high while busy");
    chk_srst_clear: assert property (@(posedge ref_clk) disable iff (sys_rst || !clk_en) // R16
        srst_req |=> ##1 (!main_ctl.enable && region == 4'h0 && status == 2'h0))
        else $error("self-reset did not clear registers");
    chk_nmi_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst) // R17
        nmi_req |=> nmi_req && cpu_stall == $past(cpu_stall) || nmi_req)
        else $error("interrupt request dropped");
    chk_enable_keep: assert property (@(posedge ref_clk) disable iff (sys_rst || !clk_en) // R5
        $fell(main_ctl.enable) && !$past(srst_pend) && $past(state) == fcsc_pkg::ST_FETCH
        |-> state != fcsc_pkg::ST_IDLE)
        else $error("clearing enable aborted the running check");
    chk_launch_busy: assert property (@(posedge ref_clk) disable iff (sys_rst || !clk_en) // R4
        state == fcsc_pkg::ST_IDLE && start |=> state == fcsc_pkg::ST_WAIT && status.busy && !status.ok)
        else $error("enable write did not launch a check");
    chk_busy_fetch: assert property (@(posedge ref_clk) disable iff (sys_rst) // R15
        state == fcsc_pkg::ST_FETCH |-> status.busy)
        else $error("busy flag low during fetch");
    chk_stall_fetch: assert property (@(posedge ref_clk) disable iff (sys_rst) // R9
        cpu_stall |-> state == fcsc_pkg::ST_FETCH)
        else $error("cpu stalled outside the fetch phase");
    chk_main_lock: assert property (@(posedge ref_clk) disable iff (sys_rst) // R21
        nmi_req && !srst_pend && !init_scan_start |=> main_ctl == $past(main_ctl))
        else $error("main control changed after failure interrupt");

endmodule // fcsc_top

// File: verif/fcsc_flash_model.sv
// behavioural program flash facing the scan checker's flash port
// assumes one word answered in the cycle after each read strobe; boot/app ends of 1 and 2 pages
`timescale 1ns/1ps
`include "fcsc_consts.svh"

module fcsc_flash_model #(
    parameter int BOOT_LAST = 127,
    parameter int APP_LAST  = 255
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    // flash port
    input  fcsc_pkg::fcsc_flash_req_t flash_req,
    output logic      [15:0]          flash_rdata,
    // fault injection: flips one bit of word 5
    input  wire logic                 corrupt
);
    logic [15:0] mem [0:`FCSC_FLASH_LAST];
    logic [15:0] crc;

    // checksums go in increasing order of section end so each covers the ones before it
    initial begin
        for (int i = 0; i <= `FCSC_FLASH_LAST; i++) begin
            mem[i] = 16'(i * 16'h1357) ^ 16'ha5a5;
        end
        foreach (mem[i]) begin
            if (i == BOOT_LAST || i == APP_LAST || i == `FCSC_FLASH_LAST) begin
                mem[i] = crc;
            end
            if (i == 0) begin
                crc = `FCSC_CRC_INIT;
            end
            for (int b = 15; b >= 0; b--) begin
                crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ mem[i][b]) ? `FCSC_CRC_POLY : 16'h0000);
            end
        end
    end

    // word per strobe
    // the word stands one cycle only; afterwards the bus flips to its inverse every cycle so stale reads show up
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flash_rdata <= 16'h0000;
        end else if (flash_req.rd) begin
            flash_rdata <= mem[flash_req.addr] ^ {15'h0000, corrupt && flash_req.addr == 15'h0005};
        end else begin
            flash_rdata <= ~flash_rdata;
        end
    end
endmodule // fcsc_flash_model

// File: verif/fcsc_top_tb.sv
// self-checking bench of the flash scan checker: apb master, scoreboard monitor, flash model
// assumes one wait cycle per apb access, fuses ending boot at 1 page and app at 2 pages
`timescale 1ns/1ps
`include "fcsc_consts.svh"

module fcsc_top_tb;
    localparam logic [11:0] A_MAIN = {`FCSC_IDX_MAIN, 2'b00};
    localparam logic [11:0] A_REG  = {`FCSC_IDX_REGION, 2'b00};
    localparam logic [11:0] A_STAT = {`FCSC_IDX_STATE, 2'b00};
    logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, corrupt = 1'b0;
    logic init_scan_start = 1'b0, pready, pslverr, cpu_stall, nmi_req;
    logic [1:0]  init_scan_src = 2'h2;
    logic [11:0] paddr = 12'h000;
    logic [15:0] flash_rdata;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic [32:0] exp_q [$], mask_q [$];
    fcsc_pkg::fcsc_flash_req_t flash_req;
    int fail_count = 0, checks_done = 0, seed = 32'h6493_7580, stall_cycles = 0;

    always #10 ref_clk = ~ref_clk;

    fcsc_top u_fcsc_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_req(flash_req), .flash_rdata(flash_rdata), .boot_end(8'h01), .app_end(8'h02),
        .init_scan_start(init_scan_start), .init_scan_src(init_scan_src), .cpu_stall(cpu_stall),
        .nmi_req(nmi_req));
    fcsc_flash_model u_fcsc_flash_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .flash_req(flash_req),
        .flash_rdata(flash_rdata), .corrupt(corrupt));

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("mismatches %0d, comparisons %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e,
                       input logic [32:0] m);
        int n;
        n = 0;
        exp_q.push_back(e);
        mask_q.push_back(m);
        @(posedge ref_clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0_0000_0000, 33'h1_0000_0000);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, {1'b0, e}, 33'h1_ffff_ffff);
    endtask

    task automatic wait_idle();
        int n;
        // a whole-flash scan takes about 6200 polls
        for (n = 0; n < 8000; n++) begin
            apb(1'b0, A_STAT, 32'h0000_0000, 33'h0_0000_0000, 33'h0_0000_0000);
            if (q[0] === 1'b0) break;
        end
        if (n >= 8000) begin
            fail_count++;
            tally_and_finish();
        end
    endtask

    // scoreboard: each completed access takes the oldest expectation
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            chk({pslverr, prdata} & mask_q[0], exp_q[0]);
            void'(exp_q.pop_front());
            void'(mask_q.pop_front());
        end
    end

    // cycles with the cpu held off flash
    always @(posedge ref_clk) begin
        if (cpu_stall === 1'b1) stall_cycles <= stall_cycles + 1;
    end

    initial begin
        int n, base;
        logic [31:0] r;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(A_MAIN, 32'h0000_0000);
        rd(A_REG, 32'h0000_0000);
        wr(A_STAT, 32'h0000_00ff);
        rd(A_STAT, 32'h0000_0002);
        apb(1'b0, 12'h00c, 32'h0000_0000, 33'h1_0000_0000, 33'h1_0000_0000);
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            wr(A_REG, r);
            rd(A_REG, r & 32'h0000_0033);
        end
        wr(A_REG, 32'h0000_0002);
        base = stall_cycles;
        wr(A_MAIN, 32'h0000_0001);
        n = 0;
        while (cpu_stall !== 1'b1 && n < 10) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk(33'(n), 33'h0_0000_0003);
        rd(A_STAT, 32'h0000_0001);
        wr(A_MAIN, 32'h0000_0003);
        rd(A_MAIN, 32'h0000_0001);
        wr(A_REG, 32'h0000_0001);
        rd(A_REG, 32'h0000_0002);
        wr(A_MAIN, 32'h0000_0000);
        rd(A_STAT, 32'h0000_0001);
        wait_idle();
        chk(33'(stall_cycles - base), 33'h0_0000_0180);
        chk({32'h0000_0000, cpu_stall}, 33'h0_0000_0000);
        rd(A_STAT, 32'h0000_0002);
        for (int s = 0; s < 4; s++) begin
            wr(A_REG, 32'(s));
            wr(A_MAIN, 32'h0000_0001);
            wait_idle();
            rd(A_STAT, 32'h0000_0002);
        end
        wr(A_MAIN, 32'h0000_0002);
        wr(A_MAIN, 32'h0000_0080);
        rd(A_MAIN, 32'h0000_0002);
        rd(A_STAT, 32'h0000_0000);
        rd(A_REG, 32'h0000_0000);
        wr(A_REG, 32'h0000_0002);
        corrupt <= 1'b1;
        wr(A_MAIN, 32'h0000_0003);
        wr(A_MAIN, 32'h0000_0002);
        wait_idle();
        rd(A_STAT, 32'h0000_0000);
        chk({32'h0000_0000, nmi_req}, 33'h0_0000_0001);
        wr(A_MAIN, 32'h0000_0001);
        rd(A_MAIN, 32'h0000_0002);
        wr(A_REG, 32'h0000_0001);
        rd(A_REG, 32'h0000_0002);
        chk({32'h0000_0000, nmi_req}, 33'h0_0000_0001);
        corrupt <= 1'b0;
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        chk({32'h0000_0000, nmi_req}, 33'h0_0000_0000);
        init_scan_start <= 1'b1;
        @(posedge ref_clk);
        init_scan_start <= 1'b0;
        rd(A_MAIN, 32'h0000_0001);
        rd(A_REG, 32'h0000_0012);
        wait_idle();
        rd(A_STAT, 32'h0000_0002);
        // software puts the access setting back to priority
        wr(A_REG, 32'h0000_0002);
        rd(A_REG, 32'h0000_0002);
        repeat (4) @(posedge ref_clk);
        tally_and_finish();
    end
endmodule // fcsc_top_tb
